// ### hw/sat_clock_enables.v
// Tick generator: system/12 and synchronised external/8 enables.
`timescale 1ns/1ps
`default_nettype none
`include "sat_timer_defines.vh"
module sat_clock_enables (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       extClk,
  output reg        tickDiv12,
  output reg        tickExt8
);
  reg  [3:0] div12_q;
  reg        extSync1_q;
  reg        extSync2_q;
  reg        extPrev_q;
  reg  [2:0] ext8_q;

  // -----------------------------------------------------------------
  // Divide-by-12 enable from the system clock.
  // -----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      div12_q   <= 4'h0;
      tickDiv12 <= 1'b0;
    end else begin
      tickDiv12 <= (div12_q == (`SAT_SYS_DIV - 4'h1));
      if (div12_q == (`SAT_SYS_DIV - 4'h1))
        div12_q <= 4'h0;
      else
        div12_q <= div12_q + 4'h1;
    end
  end

  // Two-stage synchroniser then rising-edge count; only the second
  // stage is looked at, so a metastable first stage never leaks.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
      extPrev_q  <= 1'b0;
      ext8_q     <= 3'h0;
      tickExt8   <= 1'b0;
    end else begin
      extSync1_q <= extClk;
      extSync2_q <= extSync1_q;
      extPrev_q  <= extSync2_q;
      tickExt8   <= 1'b0;
      if (extSync2_q && !extPrev_q) begin
        ext8_q <= ext8_q + 3'h1;
        if (ext8_q == `SAT_EXT_DIV)
          tickExt8 <= 1'b1;
      end
    end
  end
endmodule // sat_clock_enables
`default_nettype wire

// ### hw/sat_timer.v
// Split auto-reload timer with its special function registers.
`timescale 1ns/1ps
`default_nettype none
`include "sat_timer_defines.vh"
module sat_timer (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire [7:0] sfrAddr,
  input  wire       sfrWrite,
  input  wire       sfrRead,
  input  wire [7:0] sfrWdata,
  output reg  [7:0] sfrRdata,
  input  wire       timerIrqEnable,
  input  wire       highByteClockSelect,
  input  wire       lowByteClockSelect,
  input  wire       extClk,
  output wire       irqRequest
);
  reg  [7:0] ctrl_q;
  reg  [7:0] reloadLo_q;
  reg  [7:0] reloadHi_q;
  reg  [7:0] countLo_q;
  reg  [7:0] countHi_q;
  wire       tickDiv12;
  wire       tickExt8;
  wire       splitMode;
  wire       runBit;
  wire       tickLo;
  wire       tickHi;
  wire       advLo;
  wire       advHi;
  wire       wrapLo;
  wire       wrapHi;
  reg        setHigh;
  reg        setLow;
  wire       wrCtrl;
  wire       wrReloadLo;
  wire       wrReloadHi;
  wire       wrCountLo;
  wire       wrCountHi;

  // -----------------------------------------------------------------
  // Clock enables
  // -----------------------------------------------------------------
  sat_clock_enables uClk (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .extClk    (extClk),
    .tickDiv12 (tickDiv12),
    .tickExt8  (tickExt8)
  );

  // Pick a byte's tick: system clock, or divided source by xclk.
  function pickTick;
    input sel;
    input xclk;
    input d12;
    input e8;
    begin
      pickTick = sel ? 1'b1 : (xclk ? e8 : d12);
    end
  endfunction

  assign splitMode = ctrl_q[`SAT_BIT_SPLIT];
  assign runBit    = ctrl_q[`SAT_BIT_RUN];
  assign tickLo = pickTick(lowByteClockSelect, ctrl_q[`SAT_BIT_XCLK],
                           tickDiv12, tickExt8);
  assign tickHi = pickTick(highByteClockSelect, ctrl_q[`SAT_BIT_XCLK],
                           tickDiv12, tickExt8);

  // Low byte runs freely in split mode; the 16-bit counter advances
  // on the low-byte tick so both halves stay in step.
  assign advLo = splitMode ? tickLo : (tickLo && runBit);
  assign advHi = splitMode ? (tickHi && runBit)
                           : (advLo && countLo_q == 8'hFF);
  assign wrapLo = advLo && (countLo_q == 8'hFF);
  assign wrapHi = advHi && (countHi_q == 8'hFF);

  // Write hit on one register address; one decode keeps every
  // register's write condition identical.
  function wrHit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wrHit = wr && (addr == target);
    end
  endfunction

  assign wrCtrl     = wrHit(sfrWrite, sfrAddr, `SAT_ADDR_CTRL);
  assign wrReloadLo = wrHit(sfrWrite, sfrAddr, `SAT_ADDR_RELOAD_LO);
  assign wrReloadHi = wrHit(sfrWrite, sfrAddr, `SAT_ADDR_RELOAD_HI);
  assign wrCountLo  = wrHit(sfrWrite, sfrAddr, `SAT_ADDR_COUNT_LO);
  assign wrCountHi  = wrHit(sfrWrite, sfrAddr, `SAT_ADDR_COUNT_HI);

  // -----------------------------------------------------------------
  // Counters
  // -----------------------------------------------------------------
  // A write to a count byte wins over a tick in the same cycle.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      countLo_q <= `SAT_BYTE_RESET;
      countHi_q <= `SAT_BYTE_RESET;
    end else begin
      if (wrCountLo)
        countLo_q <= sfrWdata;
      else if (!splitMode && wrapHi)
        countLo_q <= reloadLo_q;
      else if (splitMode && wrapLo)
        countLo_q <= reloadLo_q;
      else if (advLo)
        countLo_q <= countLo_q + 8'h01;
      if (wrCountHi)
        countHi_q <= sfrWdata;
      else if (wrapHi)
        countHi_q <= reloadHi_q;
      else if (advHi)
        countHi_q <= countHi_q + 8'h01;
    end
  end

  // -----------------------------------------------------------------
  // Control and reload registers
  // -----------------------------------------------------------------
  // Flags are sticky; an overflow in the cycle of a clearing write
  // keeps the flag set so no event is lost.
  always @* begin
    setHigh = wrapHi;
    setLow  = wrapLo;
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q     <= `SAT_CTRL_RESET;
      reloadLo_q <= `SAT_BYTE_RESET;
      reloadHi_q <= `SAT_BYTE_RESET;
    end else begin
      if (wrCtrl)
        ctrl_q <= sfrWdata & `SAT_CTRL_WMASK;
      if (setHigh)
        ctrl_q[`SAT_BIT_HFLAG] <= 1'b1;
      if (setLow)
        ctrl_q[`SAT_BIT_LFLAG] <= 1'b1;
      if (wrReloadLo)
        reloadLo_q <= sfrWdata;
      if (wrReloadHi)
        reloadHi_q <= sfrWdata;
    end
  end

  // -----------------------------------------------------------------
  // Read data, registered one cycle after the read strobe
  // -----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead) begin
      case (sfrAddr)
        `SAT_ADDR_CTRL:      sfrRdata <= ctrl_q & `SAT_CTRL_WMASK;
        `SAT_ADDR_RELOAD_LO: sfrRdata <= reloadLo_q;
        `SAT_ADDR_RELOAD_HI: sfrRdata <= reloadHi_q;
        `SAT_ADDR_COUNT_LO:  sfrRdata <= countLo_q;
        `SAT_ADDR_COUNT_HI:  sfrRdata <= countHi_q;
        default:             sfrRdata <= 8'h00;
      endcase
    end
  end

  // One shared level request; software tells sources apart by flags.
  assign irqRequest = timerIrqEnable &&
    (ctrl_q[`SAT_BIT_HFLAG] ||
     (ctrl_q[`SAT_BIT_LIEN] && ctrl_q[`SAT_BIT_LFLAG]));
endmodule // sat_timer
`default_nettype wire

// ### hw/sat_timer_defines.vh
// Constants for the split auto-reload timer block.
`ifndef SAT_TIMER_DEFINES_VH
`define SAT_TIMER_DEFINES_VH
// -----------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------
`define SAT_ADDR_CTRL      8'h91
`define SAT_ADDR_RELOAD_LO 8'h92
`define SAT_ADDR_RELOAD_HI 8'h93
`define SAT_ADDR_COUNT_LO  8'h94
`define SAT_ADDR_COUNT_HI  8'h95
// -----------------------------------------------------------------
// Control register fields and reset
// -----------------------------------------------------------------
`define SAT_BIT_HFLAG  7
`define SAT_BIT_LFLAG  6
`define SAT_BIT_LIEN   5
`define SAT_BIT_SPLIT  3
`define SAT_BIT_RUN    2
`define SAT_BIT_XCLK   0
`define SAT_CTRL_WMASK 8'hED
`define SAT_CTRL_RESET 8'h00
`define SAT_BYTE_RESET 8'h00
// -----------------------------------------------------------------
// Clock dividers
// -----------------------------------------------------------------
`define SAT_SYS_DIV    4'hC
`define SAT_EXT_DIV    3'h7
`endif

// ### testbench/sat_cpu_model.sv
// Processor core model issuing register accesses to the timer.
`timescale 1ns/1ps
`default_nettype none
module sat_cpu_model (
  input  wire logic       clk_sys,
  output var  logic [7:0] sfrAddr,
  output var  logic       sfrWrite,
  output var  logic       sfrRead,
  output var  logic [7:0] sfrWdata,
  input  wire logic [7:0] sfrRdata
);
  // Idle bus; the data lines are inverted on release.
  initial begin
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    sfrWdata = 8'h00;
  end
  // A write is one strobe cycle launched on a falling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clk_sys);
    sfrWrite = 1'b0;
    sfrWdata = ~d;
  endtask
  // Read data is taken a full cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clk_sys);
    sfrRead = 1'b0;
    @(negedge clk_sys);
    d = sfrRdata;
  endtask
endmodule // sat_cpu_model
`default_nettype wire

// ### testbench/sat_timer_checker.sv
// Concurrent checks on the timer register port and interrupt line.
`timescale 1ns/1ps
`default_nettype none
module sat_timer_checker (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrite,
  input wire logic       sfrRead,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic       timerIrqEnable,
  input wire logic       irqRequest
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Write of a register followed at once by its read.
  sequence wr_rd(a);
    sfrWrite && sfrAddr == a ##1 sfrRead && sfrAddr == a;
  endsequence
  sequence ctl_wr;
    sfrWrite && sfrAddr == 8'h91;
  endsequence
  chk_unused_zero: assert property (sfrRead && sfrAddr == 8'h91
    |=> (sfrRdata & 8'h12) == 8'h00) else $error("Unused bits set.");
  chk_unmapped_zero: assert property (sfrRead
    && (sfrAddr < 8'h91 || sfrAddr > 8'h95) |=> sfrRdata == 8'h00)
    else $error("Unmapped data.");
  chk_rdata_holds: assert property (!sfrRead
    |=> $stable(sfrRdata)) else $error("Read data moved.");
  chk_reload_lo: assert property (wr_rd(8'h92)
    |=> sfrRdata == $past(sfrWdata, 2)) else $error("Low reload lost.");
  chk_reload_hi: assert property (wr_rd(8'h93)
    |=> sfrRdata == $past(sfrWdata, 2)) else $error("High reload lost.");
  chk_ctrl_bits: assert property (wr_rd(8'h91)
    |=> (sfrRdata & 8'h2D) == ($past(sfrWdata, 2) & 8'h2D))
    else $error("Control bits lost.");
  chk_irq_gated: assert property (!timerIrqEnable
    |-> !irqRequest) else $error("Request while disabled.");
  chk_flag_sticky: assert property (irqRequest
    && !(sfrWrite && sfrAddr == 8'h91) ##1 timerIrqEnable |-> irqRequest)
    else $error("Flag self cleared.");
  chk_flag_irq: assert property (ctl_wr ##0 sfrWdata[7]
    ##1 timerIrqEnable |-> irqRequest) else $error("Flag gave no request.");
endmodule // sat_timer_checker
bind sat_timer sat_timer_checker chk (.clk_sys(clk_sys), .rstn(rstn),
  .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
  .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
  .timerIrqEnable(timerIrqEnable), .irqRequest(irqRequest));
`default_nettype wire

// ### testbench/sat_timer_tb.sv
// Self-checking bench for the split auto-reload timer.
`timescale 1ns/1ps
`default_nettype none
module sat_timer_tb;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       irqEn = 1'b0;
  logic       hiSel = 1'b0;
  logic       loSel = 1'b1;
  logic       extClk = 1'b0;
  logic [7:0] rv;
  wire  [7:0] sfrAddr, sfrWdata, sfrRdata;
  wire        sfrWrite, sfrRead, irqRequest;
  int         fail_count = 0;
  int         checks_done = 0;
  // System clock at 100 MHz; free running oscillator, 6 cycles a period.
  always #5 clk_sys = ~clk_sys;
  always #30 extClk = ~extClk;
  sat_cpu_model cpu (.clk_sys(clk_sys), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata));
  sat_timer uut (.clk_sys(clk_sys), .rstn(rstn), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .timerIrqEnable(irqEn),
    .highByteClockSelect(hiSel), .lowByteClockSelect(loSel),
    .extClk(extClk), .irqRequest(irqRequest));
  // -----------------------------------------------------------------
  // Compare helpers
  // -----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Ranges absorb the unknown phase of the divided ticks.
  task automatic chkr(input string n, input logic [7:0] a, lo, hi);
    cpu.rd(a, rv);
    checks_done++;
    if ((rv >= lo && rv <= hi) !== 1'b1) begin
      fail_count++;
      $display("wrong value %s expected %h..%h seen %h", n, lo, hi, rv);
    end
  endtask
  task automatic rdc(input string n, input logic [7:0] a, e);
    cpu.rd(a, rv);
    chk(n, e, rv);
  endtask
  task automatic irq(input logic e);
    chk("irq", {7'h00, e}, {7'h00, irqRequest});
  endtask
  task automatic t_regs;
    for (int a = 8'h90; a < 8'h97; a++)
      rdc("reset", a[7:0], 8'h00);
    cpu.wr(8'h91, 8'hFF);
    rdc("ctrl", 8'h91, 8'hED);
    irq(1'b0);
    cpu.wr(8'h92, 8'hA5);
    rdc("rlo", 8'h92, 8'hA5);
    cpu.wr(8'h93, 8'h5A);
    rdc("rhi", 8'h93, 8'h5A);
    cpu.wr(8'h91, 8'h00);
  endtask
  task automatic t_wide;
    cpu.wr(8'h94, 8'hFD);
    cpu.wr(8'h95, 8'hFF);
    cpu.wr(8'h92, 8'h34);
    cpu.wr(8'h93, 8'h12);
    irqEn = 1'b1;
    cpu.wr(8'h91, 8'h04);
    repeat (20) @(negedge clk_sys);
    rdc("flags", 8'h91, 8'hC4);
    rdc("hi", 8'h95, 8'h12);
    irq(1'b1);
    cpu.wr(8'h91, 8'h00);
    irq(1'b0);
    cpu.wr(8'h94, 8'hF0);
    cpu.wr(8'h95, 8'h00);
    cpu.wr(8'h91, 8'h24);
    repeat (30) @(negedge clk_sys);
    rdc("lflag", 8'h91, 8'h64);
    rdc("carry", 8'h95, 8'h01);
    irq(1'b1);
    cpu.wr(8'h91, 8'h44);
    irq(1'b0);
    // A flag set by software requests too; this also stops the count.
    cpu.wr(8'h91, 8'h80);
    irq(1'b1);
  endtask
  // Split mode is entered first so a running 16-bit count cannot
  // disturb the byte values loaded below.
  task automatic t_split;
    hiSel = 1'b1;
    cpu.wr(8'h91, 8'h08);
    cpu.wr(8'h92, 8'h80);
    cpu.wr(8'h93, 8'h5A);
    cpu.wr(8'h95, 8'hF0);
    cpu.wr(8'h94, 8'hFE);
    repeat (20) @(negedge clk_sys);
    rdc("hold", 8'h95, 8'hF0);
    rdc("sflag", 8'h91, 8'h48);
    irq(1'b0);
    chkr("slo", 8'h94, 8'h80, 8'hA0);
    cpu.wr(8'h91, 8'h0C);
    repeat (30) @(negedge clk_sys);
    rdc("hflag", 8'h91, 8'h8C);
    irq(1'b1);
    chkr("shi", 8'h95, 8'h55, 8'h70);
  endtask
  task automatic t_clk;
    hiSel = 1'b0;
    loSel = 1'b0;
    cpu.wr(8'h94, 8'h00);
    repeat (126) @(negedge clk_sys);
    chkr("d12", 8'h94, 8'h09, 8'h0B);
    // Source switched before the clear so no late divide-by-12 tick
    // lands on the freshly cleared byte.
    cpu.wr(8'h91, 8'h09);
    cpu.wr(8'h94, 8'h00);
    repeat (264) @(negedge clk_sys);
    chkr("ext8", 8'h94, 8'h04, 8'h06);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog well beyond the fewer than 600 cycles the run needs.
  initial begin
    #50000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    t_regs();
    t_wide();
    t_split();
    t_clk();
    stop_test();
  end
endmodule // sat_timer_tb
`default_nettype wire
